// ===== rtl/sched_pkg.sv
package sched_pkg;

  // ***
  // Timing
  // ***
  localparam int CLK_MHZ   = 25;
  // Sixteen minor slots fill one second of on-board time
  localparam int MINOR_US  = 62500;
  localparam int MINOR_CYC = MINOR_US * CLK_MHZ;
  // Least gap between two transfers of one type to one user
  localparam int GAP_US    = 4000;
  localparam int GAP_CYC   = GAP_US * CLK_MHZ;
  localparam int SLOTS     = 16;
  localparam int USERS     = 8;

  // ***
  // Packet limits and addressing
  // ***
  localparam int LEN_W                 = 11;
  localparam logic [LEN_W-1:0] TM_MAX  = 11'h400;
  localparam logic [LEN_W-1:0] TC_MAX  = 11'h0f8;
  localparam logic [LEN_W-1:0] ATC_MAX = 11'h040;
  localparam logic [LEN_W-1:0] TIME_LEN = 11'h004;
  localparam logic [4:0] RT_BASE  = 5'h01;
  localparam logic [4:0] RT_BCAST = 5'h1f;
  localparam logic [4:0] SA_TM    = 5'h01;
  localparam logic [4:0] SA_TC    = 5'h01;
  localparam logic [4:0] SA_ATC   = 5'h02;
  localparam logic [4:0] SA_TIME  = 5'h03;
  localparam logic [4:0] SA_ANC   = 5'h04;
  localparam logic [4:0] SA_STAT  = 5'h1e;
  localparam logic [3:0] SLOT_SYNC = 4'h0;
  localparam logic [3:0] SLOT_ANC  = 4'h1;
  // Terminal status word flag positions
  localparam int ST_MSG_ERR = 10;
  localparam int ST_SUBSYS  = 2;
  localparam int ST_TERM    = 0;

  // ***
  // Types
  // ***
  typedef enum logic [2:0] {K_SYNC, K_ANC, K_ATC, K_TM, K_TC, K_STAT} xfer_kind_t;

  typedef struct packed {
    xfer_kind_t       kind;
    logic [4:0]       rt;
    logic [4:0]       sa;
    logic             tx;
    logic [LEN_W-1:0] len;
    logic [31:0]      data;
  } bus_cmd_t;

  typedef struct packed {
    logic        done;
    logic        err;
    logic [15:0] status;
  } xfer_rsp_t;

  typedef struct packed {
    logic [4:0]       rt;
    logic [4:0]       sa;
    logic [LEN_W-1:0] len;
  } atc_req_t;

endpackage

// ===== rtl/two_entry_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
  parameter int W = 8
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);

  logic [W-1:0] head;
  logic [W-1:0] tail;
  logic [1:0]   count;
  logic [W-1:0] next_head;
  logic [W-1:0] next_tail;
  logic [1:0]   next_count;
  logic         push;
  logic         pop;

  // Ready only while a slot is free, so a stalled drain stops the source
  assign o_in_ready  = (count != 2'h2);
  assign o_out_valid = (count != 2'h0);
  assign o_out_data  = head;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Head is the oldest word; tail only holds the second one
  always_comb begin
    next_head  = head;
    next_tail  = tail;
    next_count = count;
    case ({push, pop})
      2'b10: begin
        if (count == 2'h0) begin
          next_head = i_in_data;
        end else begin
          next_tail = i_in_data;
        end
        next_count = count + 2'h1;
      end
      2'b01: begin
        next_head  = tail;
        next_count = count - 2'h1;
      end
      2'b11: begin
        if (count == 2'h1) begin
          next_head = i_in_data;
        end else begin
          next_head = tail;
          next_tail = i_in_data;
        end
      end
      default: begin
        next_count = count;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      head  <= '0;
      tail  <= '0;
      count <= 2'h0;
    end else begin
      head  <= next_head;
      tail  <= next_tail;
      count <= next_count;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/gap_timer_bank.sv
`timescale 1ns/1ps
`default_nettype none
module gap_timer_bank #(
  parameter int CH  = 16,
  parameter int CYC = sched_pkg::GAP_CYC
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst_n,
  input  wire logic [CH-1:0] i_start,
  output logic [CH-1:0]      o_idle
);

  localparam int CW = $clog2(CYC + 1);

  logic [CW-1:0] cnt [CH];
  logic [CW-1:0] next_cnt [CH];

  // A start reloads the full gap; the channel is idle once it reaches zero
  always_comb begin
    for (int c = 0; c < CH; c++) begin
      if (i_start[c]) begin
        next_cnt[c] = CW'(CYC);
      end else if (cnt[c] != '0) begin
        next_cnt[c] = cnt[c] - CW'(1);
      end else begin
        next_cnt[c] = cnt[c];
      end
      o_idle[c] = (cnt[c] == '0);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int c = 0; c < CH; c++) begin
        cnt[c] <= '0;
      end
    end else begin
      for (int c = 0; c < CH; c++) begin
        cnt[c] <= next_cnt[c];
      end
    end
  end

endmodule
`default_nettype wire

// ===== rtl/periodic_bus_schedule_controller.sv
// What this block does
// - Commands and answers follow the standard command/response bus protocol.
// - The central data handling unit is the only bus controller.
// - Only the controller starts and sequences packet transfers.
// - The periodic schedule is locked to the on-board time second.
// - Every user is served at least twice a second, evenly spaced.
// - The schedule carries at most 21376 octets (about 171 kbps) of packet traffic a second.
// - Same-type transfers to one user are at least 4 ms apart.
// - Telemetry, telecommand and control packets are routed between users.
// - Time synchronisation and time value go out to all users.
// - Short asynchronous telecommands of up to 64 octets can be sent.
// - Broadcast messages carry system ancillary data.
// - The controller collects terminal fault and status words.
// - Telemetry at most 1024 octets, telecommand at most 248 octets.
// - Each packet moves in one unbroken transaction with its terminal.
// - Packet subaddresses lie in 1 to 30, transmit or receive.
`timescale 1ns/1ps
`default_nettype none
module periodic_bus_schedule_controller #(
  parameter int USERS     = sched_pkg::USERS,
  parameter int MINOR_CYC = sched_pkg::MINOR_CYC,
  parameter int GAP_CYC   = sched_pkg::GAP_CYC
) (
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_rst_n,
  input  wire logic                           i_sec_tick,
  input  wire logic [31:0]                    i_obt,
  input  wire logic [USERS-1:0]               i_tm_req,
  input  wire logic [USERS-1:0]               i_tc_req,
  input  wire logic [USERS*sched_pkg::LEN_W-1:0] i_tm_len,
  input  wire logic [USERS*sched_pkg::LEN_W-1:0] i_tc_len,
  input  wire logic                           i_atc_valid,
  input  wire sched_pkg::atc_req_t            i_atc,
  output logic                                o_atc_ready,
  input  wire logic                           i_anc_valid,
  input  wire logic [31:0]                    i_anc_word,
  output logic                                o_anc_ready,
  output logic                                o_cmd_valid,
  output sched_pkg::bus_cmd_t                 o_cmd,
  input  wire logic                           i_cmd_ready,
  input  wire sched_pkg::xfer_rsp_t           i_rsp,
  input  wire logic [USERS-1:0]               i_fault_clr,
  output logic [USERS-1:0]                    o_tm_grant,
  output logic [USERS-1:0]                    o_tc_grant,
  output logic [USERS-1:0]                    o_fault,
  output logic                                o_reject,
  output logic                                o_overrun,
  output logic [3:0]                          o_slot,
  output logic [23:0]                         o_sec_octets
);

  localparam int UW = (USERS > 1) ? $clog2(USERS) : 1;
  localparam int DW = $clog2(MINOR_CYC);
  localparam int LW = sched_pkg::LEN_W;

  typedef enum logic [2:0] {
    PH_IDLE, PH_SYNC, PH_ANC, PH_ATC, PH_TM, PH_TC, PH_STAT, PH_WAIT
  } phase_t;

  // ***
  // Helpers
  // ***
  function automatic logic [USERS-1:0] onehot(input logic [UW-1:0] u);
    logic [USERS-1:0] v;
    v    = '0;
    v[u] = 1'b1;
    return v;
  endfunction

  function automatic logic sa_ok(input logic [4:0] sa);
    return (sa != 5'h00) && (sa != 5'h1f);
  endfunction

  function automatic logic len_ok(input logic [LW-1:0] len, input logic [LW-1:0] max);
    return (len != '0) && (len <= max);
  endfunction

  // ***
  // Slot timing
  // ***
  logic [DW-1:0] div;
  logic [DW-1:0] next_div;
  logic [3:0]    slot;
  logic [3:0]    next_slot;
  logic          start;
  logic          next_start;
  logic [23:0]   acc;
  logic [23:0]   next_acc;
  logic [23:0]   next_sec_octets;
  logic [LW-1:0] add;

  // second mark restarts
  // The second mark re-phases the divider so slot 0 opens each second
  always_comb begin
    next_start = 1'b0;
    next_div   = div + DW'(1);
    next_slot  = slot;
    if (i_sec_tick) begin
      next_div   = '0;
      next_slot  = 4'h0;
      next_start = 1'b1;
    end else if (div == DW'(MINOR_CYC - 1)) begin
      next_div   = '0;
      next_slot  = (slot == 4'(sched_pkg::SLOTS - 1)) ? 4'h0 : slot + 4'h1;
      next_start = 1'b1;
    end
  end

  // throughput tally
  // Octets of the last second, for traffic control above us
  always_comb begin
    next_sec_octets = i_sec_tick ? acc : o_sec_octets;
    next_acc        = (i_sec_tick ? 24'h000000 : acc) + 24'(add);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div          <= '0;
      slot         <= 4'h0;
      start        <= 1'b0;
      acc          <= 24'h000000;
      o_sec_octets <= 24'h000000;
    end else begin
      div          <= next_div;
      slot         <= next_slot;
      start        <= next_start;
      acc          <= next_acc;
      o_sec_octets <= next_sec_octets;
    end
  end

  assign o_slot = slot;

  // ***
  // Scheduler
  // ***
  phase_t              phase;
  phase_t              next_phase;
  phase_t              ret;
  phase_t              next_ret;
  phase_t              after;
  sched_pkg::bus_cmd_t cur;
  sched_pkg::bus_cmd_t next_cur;
  sched_pkg::bus_cmd_t cmd;
  logic [UW-1:0]       cur_user;
  logic [UW-1:0]       next_cur_user;
  logic [UW-1:0]       user;
  logic                anc_pend;
  logic                next_anc_pend;
  logic [31:0]         anc_word;
  logic [31:0]         next_anc_word;
  logic [USERS-1:0]    next_fault;
  logic [USERS-1:0]    next_tm_grant;
  logic [USERS-1:0]    next_tc_grant;
  logic                next_reject;
  logic                next_overrun;
  logic [2*USERS-1:0]  gap_start;
  logic [2*USERS-1:0]  gap_idle;
  logic                want;
  logic                bad;
  logic                push;
  logic                buf_ready;
  logic                rsp_err;
  logic [LW-1:0]       tm_len;
  logic [LW-1:0]       tc_len;

  // users interleaved
  // Sixteen slots over eight users: each served twice a second
  assign user   = UW'(slot % 4'(USERS));
  assign tm_len = i_tm_len[user*LW +: LW];
  assign tc_len = i_tc_len[user*LW +: LW];

  assign o_anc_ready = !anc_pend;

  assign rsp_err = i_rsp.err || i_rsp.status[sched_pkg::ST_MSG_ERR]
                 || i_rsp.status[sched_pkg::ST_SUBSYS] || i_rsp.status[sched_pkg::ST_TERM];

  // One slot: sync, ancillary, async, TM, TC, status
  always_comb begin
    next_phase    = phase;
    next_ret      = ret;
    next_cur      = cur;
    next_cur_user = cur_user;
    next_anc_pend = anc_pend;
    next_anc_word = anc_word;
    next_fault    = o_fault & ~i_fault_clr;
    next_tm_grant = '0;
    next_tc_grant = '0;
    next_reject   = 1'b0;
    next_overrun  = 1'b0;
    gap_start     = '0;
    add           = '0;
    want          = 1'b0;
    bad           = 1'b0;
    push          = 1'b0;
    after         = PH_IDLE;
    o_atc_ready   = 1'b0;
    cmd           = '0;
    if (i_anc_valid && !anc_pend) begin
      next_anc_pend = 1'b1;
      next_anc_word = i_anc_word;
    end
    // A boundary that finds the slot unfinished is dropped
    if (start && phase != PH_IDLE) begin
      next_overrun = 1'b1;
    end
    case (phase)
      PH_IDLE: begin
        if (start) begin
          next_phase = PH_SYNC;
        end
      end
      PH_SYNC: begin
        want      = (slot == sched_pkg::SLOT_SYNC);
        cmd.kind  = sched_pkg::K_SYNC;
        cmd.rt    = sched_pkg::RT_BCAST;
        cmd.sa    = sched_pkg::SA_TIME;
        cmd.len   = sched_pkg::TIME_LEN;
        cmd.data  = i_obt;
        after     = PH_ANC;
      end
      PH_ANC: begin
        want      = (slot == sched_pkg::SLOT_ANC) && anc_pend;
        cmd.kind  = sched_pkg::K_ANC;
        cmd.rt    = sched_pkg::RT_BCAST;
        cmd.sa    = sched_pkg::SA_ANC;
        cmd.len   = sched_pkg::TIME_LEN;
        cmd.data  = anc_word;
        after     = PH_ATC;
      end
      PH_ATC: begin
        want      = i_atc_valid;
        bad       = !len_ok(i_atc.len, sched_pkg::ATC_MAX) || !sa_ok(i_atc.sa);
        cmd.kind  = sched_pkg::K_ATC;
        cmd.rt    = i_atc.rt;
        cmd.sa    = i_atc.sa;
        cmd.len   = i_atc.len;
        after     = PH_TM;
      end
      PH_TM: begin
        want      = i_tm_req[user] && gap_idle[user];
        bad       = !len_ok(tm_len, sched_pkg::TM_MAX);
        cmd.kind  = sched_pkg::K_TM;
        cmd.rt    = sched_pkg::RT_BASE + 5'(user);
        cmd.sa    = sched_pkg::SA_TM;
        cmd.tx    = 1'b1;
        cmd.len   = tm_len;
        after     = PH_TC;
      end
      PH_TC: begin
        want      = i_tc_req[user] && gap_idle[USERS + user];
        bad       = !len_ok(tc_len, sched_pkg::TC_MAX);
        cmd.kind  = sched_pkg::K_TC;
        cmd.rt    = sched_pkg::RT_BASE + 5'(user);
        cmd.sa    = sched_pkg::SA_TC;
        cmd.len   = tc_len;
        after     = PH_STAT;
      end
      PH_STAT: begin
        want      = 1'b1;
        cmd.kind  = sched_pkg::K_STAT;
        cmd.rt    = sched_pkg::RT_BASE + 5'(user);
        cmd.sa    = sched_pkg::SA_STAT;
        cmd.tx    = 1'b1;
        after     = PH_IDLE;
      end
      PH_WAIT: begin
        if (i_rsp.done) begin
          next_phase = ret;
          if (cur.rt != sched_pkg::RT_BCAST && rsp_err) begin
            next_fault = next_fault | onehot(cur_user);
          end
          if (cur.kind == sched_pkg::K_TM) begin
            gap_start[USERS-1:0] = onehot(cur_user);
          end
          if (cur.kind == sched_pkg::K_TC) begin
            gap_start[2*USERS-1:USERS] = onehot(cur_user);
          end
          if (!rsp_err && (cur.kind == sched_pkg::K_TM || cur.kind == sched_pkg::K_TC
                           || cur.kind == sched_pkg::K_ATC)) begin
            add = cur.len;
          end
        end
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
    if (phase != PH_IDLE && phase != PH_WAIT) begin
      bad = bad || !sa_ok(cmd.sa);
      if (!want) begin
        next_phase = after;
      end else if (bad) begin
        next_reject = 1'b1;
        next_phase  = after;
        o_atc_ready = (phase == PH_ATC);
      end else if (buf_ready) begin
        push          = 1'b1;
        next_cur      = cmd;
        next_cur_user = user;
        next_ret      = after;
        next_phase    = PH_WAIT;
        o_atc_ready   = (phase == PH_ATC);
        if (phase == PH_ANC) begin
          next_anc_pend = 1'b0;
        end
        if (phase == PH_TM) begin
          next_tm_grant = onehot(user);
        end
        if (phase == PH_TC) begin
          next_tc_grant = onehot(user);
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase      <= PH_IDLE;
      ret        <= PH_IDLE;
      cur        <= '0;
      cur_user   <= '0;
      anc_pend   <= 1'b0;
      anc_word   <= 32'h00000000;
      o_fault    <= '0;
      o_tm_grant <= '0;
      o_tc_grant <= '0;
      o_reject   <= 1'b0;
      o_overrun  <= 1'b0;
    end else begin
      phase      <= next_phase;
      ret        <= next_ret;
      cur        <= next_cur;
      cur_user   <= next_cur_user;
      anc_pend   <= next_anc_pend;
      anc_word   <= next_anc_word;
      o_fault    <= next_fault;
      o_tm_grant <= next_tm_grant;
      o_tc_grant <= next_tc_grant;
      o_reject   <= next_reject;
      o_overrun  <= next_overrun;
    end
  end

  // ***
  // Gap timers and command buffer
  // ***
  // per user timers
  gap_timer_bank #(
    .CH  (2 * USERS),
    .CYC (GAP_CYC)
  ) u_gap (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (gap_start),
    .o_idle    (gap_idle)
  );

  // commands to bus engine
  // Two entries keep a word safe while the bus engine stalls
  two_entry_buffer #(
    .W ($bits(sched_pkg::bus_cmd_t))
  ) u_buf (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (push),
    .o_in_ready  (buf_ready),
    .i_in_data   (cmd),
    .o_out_valid (o_cmd_valid),
    .i_out_ready (i_cmd_ready),
    .o_out_data  (o_cmd)
  );

endmodule
`default_nettype wire

// ===== test/sched_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sched_assertions #(
  parameter int USERS   = 8,
  parameter int GAP_CYC = 2000
) (
  input wire logic                 i_ref_clk,
  input wire logic                 i_rst_n,
  input wire logic                 o_cmd_valid,
  input wire sched_pkg::bus_cmd_t  o_cmd,
  input wire logic                 i_cmd_ready,
  input wire sched_pkg::xfer_rsp_t i_rsp,
  input wire logic [3:0]           o_slot,
  input wire logic [USERS-1:0]     o_fault
);
  logic        open;
  logic [4:0]  ort;
  logic [2:0]  okind;
  int unsigned tm_age [USERS];
  int unsigned tc_age [USERS];

  // Ages restart at done; a saturated age means the gap is over
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      open  <= 1'h0;
      ort   <= 5'h00;
      okind <= 3'h0;
      for (int u = 0; u < USERS; u++) begin
        tm_age[u] <= GAP_CYC;
        tc_age[u] <= GAP_CYC;
      end
    end else begin
      for (int u = 0; u < USERS; u++) begin
        tm_age[u] <= (tm_age[u] < GAP_CYC) ? tm_age[u] + 1 : tm_age[u];
        tc_age[u] <= (tc_age[u] < GAP_CYC) ? tc_age[u] + 1 : tc_age[u];
      end
      if (o_cmd_valid && i_cmd_ready) begin
        open  <= 1'h1;
        ort   <= o_cmd.rt;
        okind <= o_cmd.kind;
      end else if (open && i_rsp.done) begin
        open <= 1'h0;
        if (okind == sched_pkg::K_TM) tm_age[ort - 5'h01] <= 0;
        if (okind == sched_pkg::K_TC) tc_age[ort - 5'h01] <= 0;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_stall;
    o_cmd_valid && !i_cmd_ready;
  endsequence
  sequence s_bad_end;
    open && i_rsp.done && i_rsp.err && ort != sched_pkg::RT_BCAST;
  endsequence

  cmd_hold_a: assert property (s_stall |=> o_cmd_valid && $stable(o_cmd))
    else $error("command changed before taken");
  one_open_a: assert property (open |-> !o_cmd_valid)
    else $error("second command open");
  sync_form_a: assert property (o_cmd_valid && o_cmd.kind == sched_pkg::K_SYNC |->
    o_cmd.rt == sched_pkg::RT_BCAST && o_cmd.sa == sched_pkg::SA_TIME
    && o_cmd.len == sched_pkg::TIME_LEN && o_slot == sched_pkg::SLOT_SYNC)
    else $error("sync word malformed");
  sa_range_a: assert property (o_cmd_valid |-> o_cmd.sa inside {[5'h01:5'h1e]})
    else $error("subaddress out of range");
  tm_form_a: assert property (o_cmd_valid && o_cmd.kind == sched_pkg::K_TM |->
    o_cmd.tx && o_cmd.len inside {[11'h001:sched_pkg::TM_MAX]})
    else $error("telemetry word malformed");
  tc_form_a: assert property (o_cmd_valid && o_cmd.kind == sched_pkg::K_TC |->
    !o_cmd.tx && o_cmd.len inside {[11'h001:sched_pkg::TC_MAX]})
    else $error("telecommand word malformed");
  atc_len_a: assert property (o_cmd_valid && o_cmd.kind == sched_pkg::K_ATC |->
    !o_cmd.tx && o_cmd.len inside {[11'h001:sched_pkg::ATC_MAX]})
    else $error("short telecommand too long");
  tm_gap_a: assert property ($rose(o_cmd_valid) && o_cmd.kind == sched_pkg::K_TM |->
    tm_age[o_cmd.rt - 5'h01] >= GAP_CYC)
    else $error("telemetry gap too short");
  tc_gap_a: assert property ($rose(o_cmd_valid) && o_cmd.kind == sched_pkg::K_TC |->
    tc_age[o_cmd.rt - 5'h01] >= GAP_CYC)
    else $error("telecommand gap too short");
  slot_step_a: assert property ($changed(o_slot) |->
    o_slot == $past(o_slot) + 4'h1 || o_slot == 4'h0)
    else $error("slot skipped");
  fault_set_a: assert property (s_bad_end |=> o_fault[ort - 5'h01])
    else $error("error answer left no fault");
endmodule

bind periodic_bus_schedule_controller sched_assertions #(
  .USERS(USERS), .GAP_CYC(GAP_CYC)
) u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd),
  .i_cmd_ready(i_cmd_ready), .i_rsp(i_rsp), .o_slot(o_slot), .o_fault(o_fault)
);
`default_nettype wire

// ===== test/rt_model.sv
`timescale 1ns/1ps
`default_nettype none
module rt_model (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_cmd_valid,
  input  wire sched_pkg::bus_cmd_t  i_cmd,
  input  wire logic                 i_slow,
  input  wire logic                 i_err,
  output logic                      o_cmd_ready,
  output sched_pkg::xfer_rsp_t      o_rsp
);
  logic        busy;
  logic        done;
  logic        bcast;
  logic [7:0]  cnt;
  logic [15:0] noise;

  // A slow terminal stalls up to seven cycles
  // slave only
  assign o_cmd_ready = !busy && (!i_slow || noise[2:0] == 3'h0);

  // Junk on the answer lines outside done
  // status and errors
  assign o_rsp = {done, done ? (i_err && !bcast) : noise[5], done ? 16'h0000 : noise};

  // Each command ends with one done
  // serve all kinds
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy  <= 1'h0;
      done  <= 1'h0;
      bcast <= 1'h0;
      cnt   <= 8'h00;
      noise <= 16'h0001;
    end else begin
      noise <= noise + 16'h9e37;
      done  <= 1'h0;
      if (o_cmd_ready && i_cmd_valid) begin
        busy  <= 1'h1;
        bcast <= (i_cmd.rt == sched_pkg::RT_BCAST);
        cnt   <= i_slow ? 8'h1e : 8'h01;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'h0;
        done <= 1'h1;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/tb_periodic_bus_schedule_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_periodic_bus_schedule_controller;
  localparam int MINOR = 200;
  localparam int GAP   = 2000;
  logic clk = 1'h0, rst_n = 1'h0, tick = 1'h0, slow = 1'h0, err = 1'h0;
  logic atc_valid = 1'h0, anc_valid = 1'h0, took = 1'h0, ovr = 1'h0;
  logic [31:0] obt = 32'h0, anc_word = 32'h0;
  logic [7:0]  tm_req = 8'h00, tc_req = 8'h00, fault_clr = 8'h00;
  logic [87:0] tm_len = '0, tc_len = '0;
  sched_pkg::atc_req_t  atc = '0;
  sched_pkg::bus_cmd_t  cmd, got = '0;
  sched_pkg::xfer_rsp_t rsp;
  logic atc_ready, anc_ready, cmd_valid, cmd_ready, reject, overrun;
  logic [7:0]  tm_grant, tc_grant, fault;
  logic [3:0]  slot;
  logic [23:0] sec_octets;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  int stat_cnt [8];

  periodic_bus_schedule_controller #(.USERS(8), .MINOR_CYC(MINOR), .GAP_CYC(GAP)) u_dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_sec_tick(tick), .i_obt(obt), .i_tm_req(tm_req),
    .i_tc_req(tc_req), .i_tm_len(tm_len), .i_tc_len(tc_len), .i_atc_valid(atc_valid),
    .i_atc(atc), .o_atc_ready(atc_ready), .i_anc_valid(anc_valid), .i_anc_word(anc_word),
    .o_anc_ready(anc_ready), .o_cmd_valid(cmd_valid), .o_cmd(cmd), .i_cmd_ready(cmd_ready),
    .i_rsp(rsp), .i_fault_clr(fault_clr), .o_tm_grant(tm_grant), .o_tc_grant(tc_grant),
    .o_fault(fault), .o_reject(reject), .o_overrun(overrun), .o_slot(slot),
    .o_sec_octets(sec_octets));
  rt_model u_rt (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .i_slow(slow), .i_err(err), .o_cmd_ready(cmd_ready), .o_rsp(rsp));

  always #20 clk = ~clk;

  // Last word taken, polls, overruns, hang limit
  always @(posedge clk) begin
    took <= cmd_valid && cmd_ready;
    cyc  <= cyc + 1;
    if (overrun === 1'h1) ovr <= 1'h1;
    if (cmd_valid && cmd_ready) got <= cmd;
    if (cmd_valid && cmd_ready && cmd.kind == sched_pkg::K_STAT)
      stat_cnt[cmd.rt - 5'h01] <= stat_cnt[cmd.rt - 5'h01] + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic ck(input logic bad, input string m);
    checks_done++;
    if (bad !== 1'h0) begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  task automatic wait_kind(input sched_pkg::xfer_kind_t k);
    int n;
    for (n = 0; n < 4000; n++) begin
      @(negedge clk);
      if (took && got.kind == k) break;
    end
    ck(n >= 4000, "command not seen");
  endtask

  task automatic wait_bit(input int u, input logic tc, output int at);
    int n;
    for (n = 0; n < 4000; n++) begin
      @(negedge clk);
      if ((tc ? tc_grant[u] : tm_grant[u]) === 1'h1) break;
    end
    ck(n >= 4000, "grant not seen");
    at = cyc;
  endtask

  task automatic send_atc(input sched_pkg::atc_req_t r);
    int n;
    @(negedge clk);
    atc = r;
    atc_valid = 1'h1;
    for (n = 0; n < 4000 && atc_ready !== 1'h1; n++) @(negedge clk);
    ck(n >= 4000, "request not taken");
    @(negedge clk);
    atc_valid = 1'h0;
  endtask

  task automatic t_sync_anc;
    int n;
    obt  = 32'h1234_abcd;
    tick = 1'h1;
    @(negedge clk);
    tick = 1'h0;
    wait_kind(sched_pkg::K_SYNC);
    ck(got.data !== obt || slot !== sched_pkg::SLOT_SYNC, "time word wrong");
    anc_word  = 32'h5a5a_0f0f;
    anc_valid = 1'h1;
    for (n = 0; n < 40 && anc_ready !== 1'h1; n++) @(negedge clk);
    @(negedge clk);
    anc_valid = 1'h0;
    wait_kind(sched_pkg::K_ANC);
    ck(got.data !== anc_word || got.rt !== sched_pkg::RT_BCAST, "ancillary wrong");
  endtask

  task automatic t_atc;
    sched_pkg::atc_req_t bad [4] = '{'{5'h03, 5'h05, 11'h041}, '{5'h03, 5'h05, 11'h000},
      '{5'h03, 5'h00, 11'h010}, '{5'h03, 5'h1f, 11'h010}};
    send_atc('{5'h03, 5'h05, sched_pkg::ATC_MAX});
    wait_kind(sched_pkg::K_ATC);
    ck(got.rt !== 5'h03 || got.sa !== 5'h05 || got.len !== 11'h040, "short tc wrong");
    for (int i = 0; i < 4; i++) begin
      send_atc(bad[i]);
      ck(reject !== 1'h1, "bad request kept");
    end
  endtask

  task automatic t_tm_tc;
    int t0, t1;
    slow = 1'h1;
    tm_len[11+:11] = sched_pkg::TM_MAX;
    tm_req[1] = 1'h1;
    wait_bit(1, 1'h0, t0);
    wait_kind(sched_pkg::K_TM);
    ck(got.rt !== 5'h02 || got.len !== sched_pkg::TM_MAX || !got.tx, "tm wrong");
    wait_bit(1, 1'h0, t1);
    tm_req[1] = 1'h0;
    slow = 1'h0;
    ck(t1 - t0 < GAP, "tm gap short");
    tc_len[22+:11] = sched_pkg::TC_MAX;
    tc_req[2] = 1'h1;
    wait_bit(2, 1'h1, t0);
    tc_req[2] = 1'h0;
    wait_kind(sched_pkg::K_TC);
    ck(got.rt !== 5'h03 || got.len !== sched_pkg::TC_MAX || got.tx, "tc wrong");
  endtask

  task automatic t_len_refuse;
    int n;
    tm_len[44+:11] = sched_pkg::TM_MAX + 11'h001;
    tc_len[33+:11] = sched_pkg::TC_MAX + 11'h001;
    tm_req[4] = 1'h1;
    tc_req[3] = 1'h1;
    for (n = 0; n < 4000 && reject !== 1'h1; n++) @(negedge clk);
    ck(n >= 4000, "long packet kept");
    repeat (3200) @(negedge clk);
    tm_req = 8'h00;
    tc_req = 8'h00;
  endtask

  task automatic t_fault;
    int n;
    err = 1'h1;
    for (n = 0; n < 400 && fault === 8'h00; n++) @(negedge clk);
    err = 1'h0;
    ck(fault[got.rt - 5'h01] !== 1'h1, "fault bit missing");
    fault_clr = 8'hff;
    @(negedge clk);
    fault_clr = 8'h00;
    ck(fault !== 8'h00, "fault not cleared");
  endtask

  task automatic t_service;
    logic [3:0] s0;
    tick = 1'h1;
    @(negedge clk);
    tick = 1'h0;
    send_atc('{5'h03, 5'h05, sched_pkg::ATC_MAX});
    s0       = slot;
    ovr      = 1'h0;
    stat_cnt = '{default: 0};
    repeat (16 * MINOR) @(negedge clk);
    ck(slot !== s0 || ovr !== 1'h0, "period wrong");
    for (int u = 0; u < 8; u++) ck(stat_cnt[u] < 2, "user served rarely");
    tick = 1'h1;
    @(negedge clk);
    tick = 1'h0;
    ck(sec_octets !== 24'(sched_pkg::ATC_MAX), "octet tally wrong");
  endtask

  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Reset, then each scenario
  initial begin
    repeat (3) @(negedge clk);
    ck(anc_ready !== 1'h1 || cmd_valid !== 1'h0 || slot !== 4'h0, "reset state");
    rst_n = 1'h1;
    @(negedge clk);
    t_sync_anc();
    t_atc();
    t_tm_tc();
    t_len_refuse();
    t_fault();
    t_service();
    final_report();
  end
endmodule
`default_nettype wire
